// ==== chmrm_pkg.sv ====
// register map constants for the chiller register bank
// assumes the frame decoder hands over one register at a time
package chmrm_pkg;

    // ****************************************************************
    // register indices
    // ****************************************************************
    localparam logic [15:0] REG_DISCH_TEMP   = 16'h0000;
    localparam logic [15:0] REG_FLOW_RATE    = 16'h0001;
    localparam logic [15:0] REG_DISCH_PRESS  = 16'h0002;
    localparam logic [15:0] REG_CONDUCT      = 16'h0003;
    localparam logic [15:0] REG_STATUS       = 16'h0004;
    localparam logic [15:0] REG_ALARM_ONE    = 16'h0005;
    localparam logic [15:0] REG_ALARM_TWO    = 16'h0006;
    localparam logic [15:0] REG_ALARM_THREE  = 16'h0007;
    localparam logic [15:0] REG_LAST_RO      = 16'h000A;
    localparam logic [15:0] REG_SETPOINT     = 16'h000B;
    localparam logic [15:0] REG_RUN_STOP     = 16'h000C;
    localparam logic [15:0] REG_LAST         = 16'h000F;

    // ****************************************************************
    // status word bit positions
    // ****************************************************************
    localparam int ST_RUN         = 0;
    localparam int ST_STOP_ALARM  = 1;
    localparam int ST_CONT_ALARM  = 2;
    localparam int ST_PRESS_PSI   = 4;
    localparam int ST_REMOTE      = 5;
    localparam int ST_WARMUP      = 7;
    localparam int ST_TEMP_READY  = 9;
    localparam int ST_TEMP_FAHR   = 10;
    localparam int ST_RUN_TIMER   = 11;
    localparam int ST_STOP_TIMER  = 12;
    localparam int ST_RESTART     = 13;
    localparam int ST_ANTI_FREEZE = 14;
    localparam int ST_AUTO_FILL   = 15;

    // ****************************************************************
    // value ranges, in register counts
    // ****************************************************************
    localparam logic [15:0] TEMP_C_MIN   = 16'hFBB4;
    localparam logic [15:0] TEMP_C_MAX   = 16'h05DC;
    localparam logic [15:0] TEMP_F_MIN   = 16'hF984;
    localparam logic [15:0] TEMP_F_MAX   = 16'h0BCC;
    localparam logic [15:0] FLOW_MAX     = 16'h079E;
    localparam logic [15:0] PRESS_M_MAX  = 16'h012C;
    localparam logic [15:0] PRESS_P_MAX  = 16'h01B3;
    localparam logic [15:0] COND_MIN     = 16'h0014;
    localparam logic [15:0] COND_MAX     = 16'h01E0;
    localparam logic [15:0] SETP_C_MIN   = 16'h0032;
    localparam logic [15:0] SETP_C_MAX   = 16'h015E;
    localparam logic [15:0] SETP_F_MIN   = 16'h03B6;
    localparam logic [15:0] SETP_F_MAX   = 16'h0410;
    localparam logic [15:0] RUN_VALUE    = 16'h0001;

    // ****************************************************************
    // reset values and answer codes
    // ****************************************************************
    localparam logic [15:0] SETPOINT_RST = 16'h00FA;
    localparam logic [15:0] RUN_STOP_RST = 16'h0000;
    localparam logic [7:0]  ERR_NONE     = 8'h00;
    localparam logic [7:0]  ERR_ADDRESS  = 8'h02;
    localparam logic [7:0]  ERR_DATA     = 8'h03;

endpackage

// ==== chmrm_register_bank.sv ====
// chiller register bank: a sixteen-place map of 16-bit registers, two of them held (setpoint, run/stop), behind a
// decoded single-register read/write port
// assumes the serial frame handler splits multi-register requests
`timescale 1ns/1ps
`default_nettype none

module chmrm_register_bank (
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        clkEn,
    // decoded register access from the frame handler
    input  wire logic        regReq,
    input  wire logic        regWrite,
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWdata,
    // answer to the frame handler
    output logic             regAck,
    output logic             regErr,
    output logic [7:0]       regErrCode,
    output logic [15:0]      regRdata,
    // measured values, celsius and MPa based
    input  wire logic [15:0] processValueDisplay,
    input  wire logic [15:0] tempOffset,
    input  wire logic        offsetEnable,
    input  wire logic [15:0] flowRate,
    input  wire logic [15:0] pressureMpa,
    input  wire logic [15:0] conductivity,
    // unit and state inputs
    input  wire logic        unitRunning,
    input  wire logic        pumpOnlyRunning,
    input  wire logic        stopAlarmActive,
    input  wire logic        contAlarmActive,
    input  wire logic        pressUnitPsi,
    input  wire logic        serialRemote,
    input  wire logic        warmupEnabled,
    input  wire logic        tempReady,
    input  wire logic        tempUnitFahr,
    input  wire logic        runTimerEnabled,
    input  wire logic        stopTimerEnabled,
    input  wire logic        restartEnabled,
    input  wire logic        antiFreezeEnabled,
    input  wire logic        autoFillSignal,
    // alarm words
    input  wire logic [15:0] alarmWordOne,
    input  wire logic [15:0] alarmWordTwo,
    input  wire logic [15:0] alarmWordThree,
    // commands to the unit
    output logic [15:0]      fluidSetpoint,
    output logic [15:0]      runStopCommand,
    output logic             runRequest,
    output logic             commandStrobe
);
    import chmrm_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [15:0] setpoint;
        logic [15:0] runStop;
        logic        ack;
        logic        err;
        logic [7:0]  errCode;
        logic [15:0] rdata;
        logic        strobe;
    } chmrm_state_t;

    chmrm_state_t st;
    chmrm_state_t next_st;

    logic [15:0] statusWord;
    logic [15:0] tempView;
    logic [15:0] pressView;
    logic [15:0] readValue;
    logic        setpointOk;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // signed clamp into [lo, hi]
    function automatic logic [15:0] clampS(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
        if ($signed(v) < $signed(lo)) begin
            return lo;
        end else if ($signed(v) > $signed(hi)) begin
            return hi;
        end
        return v;
    endfunction

    // unsigned clamp into [lo, hi]
    function automatic logic [15:0] clampU(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // address falls in the read-only part of the map
    function automatic logic isReadOnly(input logic [15:0] a);
        return a <= REG_LAST_RO;
    endfunction

    // ****************************************************************
    // measurement views
    // ****************************************************************
    // temperature in tenths, offset then unit conversion, clamped
    always_comb begin
        logic signed [31:0] pv;
        logic signed [31:0] fa;
        pv = 32'($signed(processValueDisplay));
        fa = 32'sd0;
        if (offsetEnable) begin
            pv = pv + 32'($signed(tempOffset));
        end
        if (tempUnitFahr) begin
            fa = (pv * 32'sd9) / 32'sd5 + 32'sd320;
            tempView = clampS(16'(fa), TEMP_F_MIN, TEMP_F_MAX);
        end else begin
            tempView = clampS(16'(pv), TEMP_C_MIN, TEMP_C_MAX);
        end
    end

    // pressure in hundredths of MPa or whole PSI
    always_comb begin
        logic [31:0] ps;
        ps = (32'(pressureMpa) * 32'd145) / 32'd100;
        if (pressUnitPsi) begin
            pressView = clampU(16'(ps), 16'h0000, PRESS_P_MAX);
        end else begin
            pressView = clampU(pressureMpa, 16'h0000, PRESS_M_MAX);
        end
    end

    // ****************************************************************
    // status word
    // ****************************************************************
    always_comb begin
        statusWord                 = 16'h0000;
        statusWord[ST_RUN]         = unitRunning | pumpOnlyRunning;
        statusWord[ST_STOP_ALARM]  = stopAlarmActive;
        statusWord[ST_CONT_ALARM]  = contAlarmActive;
        statusWord[ST_PRESS_PSI]   = pressUnitPsi;
        statusWord[ST_REMOTE]      = serialRemote;
        statusWord[ST_WARMUP]      = warmupEnabled;
        statusWord[ST_TEMP_READY]  = tempReady;
        statusWord[ST_TEMP_FAHR]   = tempUnitFahr;
        statusWord[ST_RUN_TIMER]   = runTimerEnabled;
        statusWord[ST_STOP_TIMER]  = stopTimerEnabled;
        statusWord[ST_RESTART]     = restartEnabled;
        statusWord[ST_ANTI_FREEZE] = antiFreezeEnabled;
        statusWord[ST_AUTO_FILL]   = autoFillSignal;
    end

    // ****************************************************************
    // read decode
    // ****************************************************************
    always_comb begin
        if (regAddr == REG_DISCH_TEMP) begin
            readValue = tempView;
        end else if (regAddr == REG_FLOW_RATE) begin
            readValue = clampU(flowRate, 16'h0000, FLOW_MAX);
        end else if (regAddr == REG_DISCH_PRESS) begin
            readValue = pressView;
        end else if (regAddr == REG_CONDUCT) begin
            readValue = clampU(conductivity, COND_MIN, COND_MAX);
        end else if (regAddr == REG_STATUS) begin
            readValue = statusWord;
        end else if (regAddr == REG_ALARM_ONE) begin
            readValue = alarmWordOne;
        end else if (regAddr == REG_ALARM_TWO) begin
            readValue = alarmWordTwo;
        end else if (regAddr == REG_ALARM_THREE) begin
            readValue = alarmWordThree;
        end else if (regAddr == REG_SETPOINT) begin
            readValue = st.setpoint;
        end else if (regAddr == REG_RUN_STOP) begin
            readValue = st.runStop;
        end else begin
            readValue = 16'h0000;
        end
    end

    // setpoint write must lie inside the range of the selected unit
    always_comb begin
        if (tempUnitFahr) begin
            setpointOk = (regWdata >= SETP_F_MIN) && (regWdata <= SETP_F_MAX);
        end else begin
            setpointOk = (regWdata >= SETP_C_MIN) && (regWdata <= SETP_C_MAX);
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st        = st;
        next_st.ack    = 1'b0;
        next_st.strobe = 1'b0;
        if (regReq) begin
            next_st.ack     = 1'b1;
            next_st.err     = 1'b0;
            next_st.errCode = ERR_NONE;
            next_st.rdata   = 16'h0000;
            if (regAddr > REG_LAST) begin
                next_st.err     = 1'b1;
                next_st.errCode = ERR_ADDRESS;
            end else if (!regWrite) begin
                next_st.rdata = readValue;
            end else if (isReadOnly(regAddr)) begin
                next_st.rdata = regWdata;
            end else if (regAddr == REG_SETPOINT) begin
                next_st.rdata = regWdata;
                if (setpointOk) begin
                    next_st.setpoint = regWdata;
                    next_st.strobe   = 1'b1;
                end else begin
                    next_st.err     = 1'b1;
                    next_st.errCode = ERR_DATA;
                end
            end else if (regAddr == REG_RUN_STOP) begin
                next_st.rdata   = regWdata;
                next_st.runStop = regWdata;
                next_st.strobe  = 1'b1;
            end else begin
                next_st.rdata = regWdata;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st.setpoint <= SETPOINT_RST;
            st.runStop  <= RUN_STOP_RST;
            st.ack      <= 1'b0;
            st.err      <= 1'b0;
            st.errCode  <= ERR_NONE;
            st.rdata    <= 16'h0000;
            st.strobe   <= 1'b0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign regAck         = st.ack;
    assign regErr         = st.err;
    assign regErrCode     = st.errCode;
    assign regRdata       = st.rdata;
    assign fluidSetpoint  = st.setpoint;
    assign runStopCommand = st.runStop;
    assign runRequest     = (st.runStop == RUN_VALUE);
    assign commandStrobe  = st.strobe;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_range_error: assert property (
        clkEn && regReq && (regAddr > REG_LAST)
        |=> regAck && regErr && (regErrCode == ERR_ADDRESS))
        else $error("out of map access not refused with code 02");

    a_ro_write_ignored: assert property (
        clkEn && regReq && regWrite && isReadOnly(regAddr)
        |=> !regErr && $stable(fluidSetpoint) && $stable(runStopCommand))
        else $error("write to read-only register changed state");

    a_setpoint_taken: assert property (
        clkEn && regReq && regWrite && (regAddr == REG_SETPOINT) && setpointOk
        |=> (fluidSetpoint == $past(regWdata)) && commandStrobe)
        else $error("valid setpoint write not stored");

    a_run_cmd_taken: assert property (
        clkEn && regReq && regWrite && (regAddr == REG_RUN_STOP)
        && (regWdata == RUN_VALUE)
        |=> runRequest ##1 (runRequest || $past(clkEn && regReq && regWrite)))
        else $error("run command did not start operation");

    a_status_read: assert property (
        clkEn && regReq && !regWrite && (regAddr == REG_STATUS)
        |=> (regRdata == $past(statusWord))
        && (regRdata[ST_RUN] == $past(unitRunning | pumpOnlyRunning)))
        else $error("status read does not match unit state");

    a_unused_zero: assert property (
        clkEn && regReq && !regWrite && (regAddr == REG_STATUS)
        |=> (regRdata[3] == 1'b0) && (regRdata[6] == 1'b0) && (regRdata[8] == 1'b0))
        else $error("unused status bit reads nonzero");

    a_reserved_zero: assert property (
        clkEn && regReq && !regWrite && (regAddr >= 16'h0008)
        && (regAddr <= REG_LAST) && (regAddr != REG_SETPOINT)
        && (regAddr != REG_RUN_STOP)
        |=> (regRdata == 16'h0000) && !regErr)
        else $error("reserved register reads nonzero");

    a_temp_span: assert property (
        clkEn && regReq && !regWrite && (regAddr == REG_DISCH_TEMP)
        |=> ($past(tempUnitFahr) ?
             ($signed(regRdata) >= $signed(TEMP_F_MIN)
              && $signed(regRdata) <= $signed(TEMP_F_MAX)) :
             ($signed(regRdata) >= $signed(TEMP_C_MIN)
              && $signed(regRdata) <= $signed(TEMP_C_MAX))))
        else $error("temperature read outside unit span");

    a_flow_span: assert property (
        clkEn && regReq && !regWrite && (regAddr == REG_FLOW_RATE)
        |=> (regRdata <= FLOW_MAX))
        else $error("flow read above span");

    a_press_span: assert property (
        clkEn && regReq && !regWrite && (regAddr == REG_DISCH_PRESS)
        |=> (regRdata <= ($past(pressUnitPsi) ? PRESS_P_MAX : PRESS_M_MAX)))
        else $error("pressure read above unit span");

    a_ack_pulse: assert property (
        clkEn && !regReq |=> !regAck)
        else $error("answer without request");

    a_cond_span: assert property (
        clkEn && regReq && !regWrite && (regAddr == REG_CONDUCT)
        |=> (regRdata >= COND_MIN) && (regRdata <= COND_MAX))
        else $error("conductivity read outside span");

    a_bad_setpoint: assert property (
        clkEn && regReq && regWrite && (regAddr == REG_SETPOINT) && !setpointOk
        |=> regErr && (regErrCode == ERR_DATA) && $stable(fluidSetpoint) && !commandStrobe)
        else $error("setpoint outside unit range was not refused");

    a_temp_plain: assert property (
        clkEn && regReq && !regWrite && (regAddr == REG_DISCH_TEMP) && !tempUnitFahr
        && !offsetEnable && ($signed(processValueDisplay) >= $signed(TEMP_C_MIN))
        && ($signed(processValueDisplay) <= $signed(TEMP_C_MAX))
        |=> (regRdata == $past(processValueDisplay)))
        else $error("temperature read differs from displayed value");

    a_refused_no_write: assert property (
        clkEn && regReq && regWrite && (regAddr > REG_LAST)
        |=> $stable(fluidSetpoint) && $stable(runStopCommand) && !commandStrobe)
        else $error("out of map write changed state");

endmodule

`default_nettype wire

// ==== chmrm_host_model.sv ====
// host side of the decoded register port: one access at a time
// assumes a free-running core_clk and a bank that answers one cycle later
`timescale 1ns/1ps
`default_nettype none

module chmrm_host_model (
    // clock
    input  wire logic        core_clk,
    // request lines
    output logic             regReq,
    output logic             regWrite,
    output logic [15:0]      regAddr,
    output logic [15:0]      regWdata,
    // answer lines
    input  wire logic        regAck,
    input  wire logic        regErr,
    input  wire logic [7:0]  regErrCode,
    input  wire logic [15:0] regRdata
);
    // ************************************************************
    // idle state
    // ************************************************************
    // request idle from time zero
    initial begin
        regReq = 1'b0;
        regWrite = 1'b0;
        regAddr = 16'h5A5A;
        regWdata = 16'hA5A5;
    end

    // ************************************************************
    // single access
    // ************************************************************
    // drive at a falling edge, taken at the next rising edge; the answer
    // stands one cycle, so it is looked at on the following falling edge
    task automatic access(input logic wr, input logic [15:0] addr,
                          input logic [15:0] data, output logic [15:0] rdata,
                          output logic err, output logic [7:0] code,
                          output logic ack);
        @(negedge core_clk);
        regReq = 1'b1;
        regWrite = wr;
        regAddr = addr;
        regWdata = data;
        @(negedge core_clk);
        regReq = 1'b0;
        regAddr = ~addr; // released lines show no stale value
        regWdata = ~data;
        ack = regAck;
        err = regErr;
        code = regErrCode;
        rdata = regRdata;
    endtask
endmodule

`default_nettype wire

// ==== chmrm_register_bank_tb_top.sv ====
// self-checking bench for the chiller register bank
// assumes chmrm_pkg, the bank and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none

module chmrm_register_bank_tb_top;
    import chmrm_pkg::*;

    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic        regReq, regWrite, regAck, regErr, runRequest, commandStrobe;
    logic [15:0] regAddr, regWdata, regRdata, fluidSetpoint, runStopCommand;
    logic [7:0]  regErrCode;
    logic [15:0] pvd = 16'h0000, tOff = 16'h0000, flow = 16'h0000;
    logic [15:0] pMpa = 16'h0000, cond = 16'h0000, statusIn = 16'h0000;
    logic [15:0] al1 = 16'hA5C3, al2 = 16'h5A3C, al3 = 16'h0FF0;
    logic        offEn = 1'b0, pump = 1'b0;
    logic        clkEn = 1'b1, frzAck, frzErr;
    logic [7:0]  frzCode;
    logic [15:0] frzData;
    int          num_errors  = 0;
    int          checks_done = 0;

    // clock at 100 MHz
    always #5 core_clk = ~core_clk;

    chmrm_host_model hostU (.core_clk(core_clk), .regReq(regReq), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck), .regErr(regErr),
        .regErrCode(regErrCode), .regRdata(regRdata));

    chmrm_register_bank dut_u (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
        .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
        .regAck(regAck), .regErr(regErr), .regErrCode(regErrCode), .regRdata(regRdata),
        .processValueDisplay(pvd), .tempOffset(tOff), .offsetEnable(offEn),
        .flowRate(flow), .pressureMpa(pMpa), .conductivity(cond),
        .unitRunning(statusIn[0]), .pumpOnlyRunning(pump),
        .stopAlarmActive(statusIn[1]), .contAlarmActive(statusIn[2]),
        .pressUnitPsi(statusIn[4]), .serialRemote(statusIn[5]),
        .warmupEnabled(statusIn[7]), .tempReady(statusIn[9]),
        .tempUnitFahr(statusIn[10]), .runTimerEnabled(statusIn[11]),
        .stopTimerEnabled(statusIn[12]), .restartEnabled(statusIn[13]),
        .antiFreezeEnabled(statusIn[14]), .autoFillSignal(statusIn[15]),
        .alarmWordOne(al1), .alarmWordTwo(al2), .alarmWordThree(al3),
        .fluidSetpoint(fluidSetpoint), .runStopCommand(runStopCommand),
        .runRequest(runRequest), .commandStrobe(commandStrobe));

    // ************************************************************
    // compare, access and closing tasks
    // ************************************************************
    // one value comparison, counted
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one access with its whole answer compared
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       input logic [7:0] ecode, input logic [15:0] exp);
        logic [15:0] r;
        logic        e;
        logic [7:0]  c;
        logic        k;
        hostU.access(wr, a, d, r, e, c, k);
        chk({15'h0000, k}, 16'h0001);
        chk({15'h0000, e}, {15'h0000, ecode != ERR_NONE});
        chk({8'h00, c}, {8'h00, ecode});
        chk(r, exp);
    endtask

    // plain read expecting no error
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000, ERR_NONE, exp);
    endtask

    // counts, verdict, end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************************
    // watchdog and test sequence
    // ************************************************************
    // cuts a hang short well after the sequence should be over
    initial begin
        #40us;
        num_errors++;
        close_out();
    end

    // register access sequence
    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        chk(fluidSetpoint, SETPOINT_RST);
        chk(runStopCommand, RUN_STOP_RST);
        chk({15'h0000, runRequest}, 16'h0000);
        pvd = 16'h0064;
        tOff = 16'h0005;
        offEn = 1'b1;
        rd(REG_DISCH_TEMP, 16'h0069);
        offEn = 1'b0;
        rd(REG_DISCH_TEMP, 16'h0064);
        pvd = 16'hF830;
        rd(REG_DISCH_TEMP, TEMP_C_MIN);
        statusIn = 16'h0400;
        pvd = 16'h03E8;
        rd(REG_DISCH_TEMP, 16'h0848);
        pvd = 16'h05DC;
        rd(REG_DISCH_TEMP, TEMP_F_MAX);
        pvd = 16'hFBB4;
        rd(REG_DISCH_TEMP, TEMP_F_MIN);
        statusIn = 16'h0000;
        flow = 16'h0123;
        rd(REG_FLOW_RATE, 16'h0123);
        flow = 16'h0800;
        rd(REG_FLOW_RATE, FLOW_MAX);
        pMpa = 16'h0064;
        rd(REG_DISCH_PRESS, 16'h0064);
        statusIn = 16'h0010;
        rd(REG_DISCH_PRESS, 16'h0091);
        pMpa = 16'h012C;
        rd(REG_DISCH_PRESS, PRESS_P_MAX);
        rd(REG_CONDUCT, COND_MIN);
        cond = 16'h0100;
        rd(REG_CONDUCT, 16'h0100);
        cond = 16'h0300;
        rd(REG_CONDUCT, COND_MAX);
        // walk a single status input across every bit
        for (int b = 0; b < 16; b++) begin
            statusIn = 16'h0001 << b;
            rd(REG_STATUS, statusIn & 16'hFEB7);
        end
        statusIn = 16'h0000;
        pump = 1'b1;
        rd(REG_STATUS, 16'h0001);
        statusIn = 16'hFFFF;
        rd(REG_STATUS, 16'hFEB7);
        statusIn = 16'h0000;
        pump = 1'b0;
        rd(REG_ALARM_TWO, 16'h5A3C);
        rd(REG_ALARM_THREE, 16'h0FF0);
        acc(1'b1, REG_ALARM_ONE, 16'h1234, ERR_NONE, 16'h1234);
        chk({15'h0000, commandStrobe}, 16'h0000);
        rd(REG_ALARM_ONE, 16'hA5C3);
        // reserved places take writes and still read zero
        for (int a = 8; a < 16; a++) begin
            if (a == 11 || a == 12) continue;
            acc(1'b1, 16'(a), 16'hFFFF, ERR_NONE, 16'hFFFF);
            rd(16'(a), 16'h0000);
        end
        acc(1'b1, REG_SETPOINT, SETP_C_MIN, ERR_NONE, SETP_C_MIN);
        chk({15'h0000, commandStrobe}, 16'h0001);
        acc(1'b1, REG_SETPOINT, 16'h0031, ERR_DATA, 16'h0031);
        chk(fluidSetpoint, SETP_C_MIN);
        acc(1'b1, REG_SETPOINT, SETP_C_MAX, ERR_NONE, SETP_C_MAX);
        acc(1'b1, REG_SETPOINT, 16'h015F, ERR_DATA, 16'h015F);
        statusIn = 16'h0400;
        acc(1'b1, REG_SETPOINT, SETP_F_MIN, ERR_NONE, SETP_F_MIN);
        acc(1'b1, REG_SETPOINT, 16'h0411, ERR_DATA, 16'h0411);
        chk({15'h0000, commandStrobe}, 16'h0000);
        acc(1'b1, REG_SETPOINT, SETP_F_MAX, ERR_NONE, SETP_F_MAX);
        rd(REG_SETPOINT, SETP_F_MAX);
        statusIn = 16'h0000;
        acc(1'b1, REG_RUN_STOP, RUN_VALUE, ERR_NONE, RUN_VALUE);
        chk({15'h0000, runRequest}, 16'h0001);
        chk({15'h0000, commandStrobe}, 16'h0001);
        rd(REG_RUN_STOP, RUN_VALUE);
        acc(1'b1, REG_RUN_STOP, 16'h0002, ERR_NONE, 16'h0002);
        chk({15'h0000, runRequest}, 16'h0000);
        acc(1'b1, REG_RUN_STOP, 16'h0000, ERR_NONE, 16'h0000);
        // frozen bank: the request is not taken and the last answer holds
        clkEn = 1'b0;
        hostU.access(1'b1, REG_RUN_STOP, RUN_VALUE, frzData, frzErr, frzCode, frzAck);
        chk({15'h0000, frzAck}, 16'h0001);
        chk({15'h0000, frzErr}, 16'h0000);
        chk({8'h00, frzCode}, {8'h00, ERR_NONE});
        chk(frzData, 16'h0000);
        chk(runStopCommand, 16'h0000);
        clkEn = 1'b1;
        acc(1'b0, 16'h0010, 16'h0000, ERR_ADDRESS, 16'h0000);
        acc(1'b1, 16'h0100, 16'h0001, ERR_ADDRESS, 16'h0000);
        chk(runStopCommand, 16'h0000);
        close_out();
    end
endmodule

`default_nettype wire
